/* atrim_pkg.sv */
// Constants, field layout and carrier types for the converter-16 trim and lane 13-16 pattern/filter registers.
// Assumes a 16-bit register port addressed by 8-bit offsets and 14-bit signed samples.
package atrim_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SAMPLE_W = 14;

  // Register offsets.
  localparam logic [7:0] CONV16_ODD_GAIN_OFFSET_ADDR = 8'h37;
  localparam logic [7:0] CONV16_EVEN_GAIN_OFFSET_ADDR = 8'h38;
  localparam logic [7:0] LANES13_16_PATTERN_FILTER_CTRL_ADDR = 8'h39;

  // Reset values.
  localparam logic [15:0] CONV16_ODD_GAIN_OFFSET_RST = 16'h0000;
  localparam logic [15:0] CONV16_EVEN_GAIN_OFFSET_RST = 16'h0000;
  localparam logic [15:0] LANES13_16_PATTERN_FILTER_CTRL_RST = 16'h0000;

  // Field positions.
  localparam int unsigned GAIN_LSB = 11;
  localparam int unsigned OFFSET_LSB = 0;
  localparam int unsigned PRBS_LSB = 12;
  localparam int unsigned LANE13_CODE_LSB = 9;
  localparam int unsigned LANE14_CODE_LSB = 6;
  localparam int unsigned FILTER_K_LSB = 1;
  localparam int unsigned FILTER_EN_BIT = 0;

  // Bits that are stored; reserved bits read back as zero.
  localparam logic [15:0] TRIM_WMASK = 16'hfbff;
  localparam logic [15:0] PATFILT_WMASK = 16'hffdf;

  // Legal range of the filter parameter k.
  localparam logic [3:0] FILTER_K_MIN = 4'h2;
  localparam logic [3:0] FILTER_K_MAX = 4'ha;

  // Linear gain for N x 0.2 dB, unsigned with 14 fraction bits.
  localparam int unsigned GAIN_FRAC = 14;
  localparam logic [31:0][15:0] GAIN_TABLE = {
    16'h82ac, 16'h7fb2, 16'h7cca, 16'h79f3, 16'h772d, 16'h7476, 16'h71cf, 16'h6f38,
    16'h6cb0, 16'h6a37, 16'h67cc, 16'h656f, 16'h6320, 16'h60de, 16'h5eaa, 16'h5c82,
    16'h5a67, 16'h5858, 16'h5655, 16'h545e, 16'h5273, 16'h5092, 16'h4ebd, 16'h4cf2,
    16'h4b32, 16'h497b, 16'h47cf, 16'h462d, 16'h4494, 16'h4304, 16'h417e, 16'h4000};

  // Saturation limits of a 14-bit signed sample.
  localparam logic signed [19:0] SAMPLE_MAX = 20'sh01fff;
  localparam logic signed [19:0] SAMPLE_MIN = 20'shfe000;

  typedef struct packed {
    logic valid;
    logic odd;
    logic signed [13:0] data;
  } atrim_sample_t;

  typedef struct packed {
    logic [3:0] prbs_en;
    logic [2:0] lane13_code;
    logic [2:0] lane14_code;
  } atrim_pattern_t;

  typedef struct packed {
    logic enable;
    logic [3:0] k;
  } atrim_filter_t;

  // Clamps a wide intermediate back into the sample range.
  function automatic logic signed [13:0] atrim_sat14(input logic signed [19:0] v);
    logic signed [13:0] r;
    r = v[13:0];
    if (v > SAMPLE_MAX)
    begin
      r = SAMPLE_MAX[13:0];
    end
    else if (v < SAMPLE_MIN)
    begin
      r = SAMPLE_MIN[13:0];
    end
    return r;
  endfunction : atrim_sat14

  // Offset subtraction then gain, both optional, with saturation.
  function automatic logic signed [13:0] atrim_correct(input logic signed [13:0] s, input logic [15:0] reg_v,
                                                        input logic gain_en, input logic offset_en);
    logic signed [15:0] diff;
    logic signed [32:0] prod;
    logic signed [19:0] wide;
    diff = 16'(s) - (offset_en ? 16'(signed'(reg_v[OFFSET_LSB +: 10])) : 16'sh0000);
    prod = 33'(diff) * 33'(signed'({1'b0, GAIN_TABLE[reg_v[GAIN_LSB +: 5]]}));
    wide = gain_en ? {prod[32], prod[32:GAIN_FRAC]} : 20'(diff);
    return atrim_sat14(wide);
  endfunction : atrim_correct

endpackage : atrim_pkg

/* atrim_regs.sv */
// Trim register bank for converter 16 and pattern/filter control for lanes 13 to 16, with the sample trim path.
// Assumes the register port master keeps strobes one cycle long and that samples arrive synchronous to sys_clk_in.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module atrim_regs (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic global_gain_enable_in,
  input wire logic global_offset_enable_in,
  input wire logic per_lane_pattern_select_in,
  input wire atrim_pkg::atrim_sample_t sample_in,
  output atrim_pkg::atrim_sample_t sample_out,
  output atrim_pkg::atrim_pattern_t pattern_out,
  output atrim_pkg::atrim_filter_t filter_out
);

  typedef struct packed {
    logic [15:0] odd_trim;
    logic [15:0] even_trim;
    logic [15:0] pat_filt;
    logic [15:0] rdata;
    atrim_pkg::atrim_sample_t sample;
    atrim_pkg::atrim_pattern_t pattern;
    atrim_pkg::atrim_filter_t filter;
  } atrim_state_t;

  atrim_state_t state_q;
  atrim_state_t state_d;
  logic [3:0] raw_k;

  assign raw_k = state_q.pat_filt[atrim_pkg::FILTER_K_LSB +: 4];

  // Register writes, read data, sample correction and control outputs.
  always_comb
  begin
    state_d = state_q;
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        atrim_pkg::CONV16_ODD_GAIN_OFFSET_ADDR: state_d.odd_trim = reg_wdata_in & atrim_pkg::TRIM_WMASK;
        atrim_pkg::CONV16_EVEN_GAIN_OFFSET_ADDR: state_d.even_trim = reg_wdata_in & atrim_pkg::TRIM_WMASK;
        atrim_pkg::LANES13_16_PATTERN_FILTER_CTRL_ADDR: state_d.pat_filt = reg_wdata_in & atrim_pkg::PATFILT_WMASK;
        default: state_d.rdata = state_q.rdata;
      endcase
    end
    // Read data stands only in the cycle after the strobe; unmapped offsets read zero.
    state_d.rdata = 16'h0000;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        atrim_pkg::CONV16_ODD_GAIN_OFFSET_ADDR: state_d.rdata = state_q.odd_trim;
        atrim_pkg::CONV16_EVEN_GAIN_OFFSET_ADDR: state_d.rdata = state_q.even_trim;
        atrim_pkg::LANES13_16_PATTERN_FILTER_CTRL_ADDR: state_d.rdata = state_q.pat_filt;
        default: state_d.rdata = 16'h0000;
      endcase
    end
    // Each sample is trimmed with the register of its own phase.
    state_d.sample.valid = sample_in.valid;
    state_d.sample.odd = sample_in.odd;
    state_d.sample.data = atrim_pkg::atrim_correct(sample_in.data,
                                                   sample_in.odd ? state_q.odd_trim : state_q.even_trim,
                                                   global_gain_enable_in, global_offset_enable_in);
    // Per-lane pattern fields reach the generator only under per-lane select; codes pass unchanged.
    if (per_lane_pattern_select_in)
    begin
      state_d.pattern.prbs_en = state_q.pat_filt[atrim_pkg::PRBS_LSB +: 4];
      state_d.pattern.lane13_code = state_q.pat_filt[atrim_pkg::LANE13_CODE_LSB +: 3];
      state_d.pattern.lane14_code = state_q.pat_filt[atrim_pkg::LANE14_CODE_LSB +: 3];
    end
    else
    begin
      state_d.pattern = '0;
    end
    // Filter enable and k; a k outside 2..10 is clamped into the legal range.
    state_d.filter.enable = state_q.pat_filt[atrim_pkg::FILTER_EN_BIT];
    if (raw_k < atrim_pkg::FILTER_K_MIN)
    begin
      state_d.filter.k = atrim_pkg::FILTER_K_MIN;
    end
    else if (raw_k > atrim_pkg::FILTER_K_MAX)
    begin
      state_d.filter.k = atrim_pkg::FILTER_K_MAX;
    end
    else
    begin
      state_d.filter.k = raw_k;
    end
  end

  // State register with asynchronous active-low reset to constants.
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q <= '0;
      state_q.odd_trim <= atrim_pkg::CONV16_ODD_GAIN_OFFSET_RST;
      state_q.even_trim <= atrim_pkg::CONV16_EVEN_GAIN_OFFSET_RST;
      state_q.pat_filt <= atrim_pkg::LANES13_16_PATTERN_FILTER_CTRL_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_out = state_q.rdata;
  assign sample_out = state_q.sample;
  assign pattern_out = state_q.pattern;
  assign filter_out = state_q.filter;

  // Checks on the trim path, pattern routing, filter control and read timing.
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_odd_unity_gain: assert property (
      sample_in.valid && sample_in.odd && global_gain_enable_in && !global_offset_enable_in
      && state_q.odd_trim[15:11] == 5'h00 |=> sample_out.data == $past(sample_in.data))
    else $error("Odd sample changed at gain code zero.");
  // A full-scale input saturates and cannot rise, so it is left out.
  a_even_gain_rise: assert property (
      sample_in.valid && !sample_in.odd && global_gain_enable_in && !global_offset_enable_in
      && state_q.even_trim[15:11] != 5'h00 && sample_in.data > 14'sh0100 && sample_in.data < 14'sh1fff
      |=> sample_out.data > $past(sample_in.data))
    else $error("Even sample not raised by nonzero gain.");
  a_odd_offset_sub: assert property (
      sample_in.valid && sample_in.odd && !global_gain_enable_in && global_offset_enable_in
      && sample_in.data == 14'sh0000
      |=> 16'(sample_out.data) == -16'(signed'($past(state_q.odd_trim[9:0]))))
    else $error("Odd offset not subtracted.");
  a_even_offset_sub: assert property (
      sample_in.valid && !sample_in.odd && !global_gain_enable_in && global_offset_enable_in
      && sample_in.data == 14'sh0400
      |=> 16'(sample_out.data) == 16'sh0400 - 16'(signed'($past(state_q.even_trim[9:0]))))
    else $error("Even offset not subtracted.");
  a_prbs_lane_map: assert property (
      reg_wr_in && reg_addr_in == atrim_pkg::LANES13_16_PATTERN_FILTER_CTRL_ADDR ##1 per_lane_pattern_select_in
      |=> pattern_out.prbs_en == $past(reg_wdata_in[15:12], 2))
    else $error("Lane pattern enables misrouted.");
  // Codes are held against the written word, not against the stored register.
  a_pattern_codes: assert property (
      reg_wr_in && reg_addr_in == atrim_pkg::LANES13_16_PATTERN_FILTER_CTRL_ADDR ##1 per_lane_pattern_select_in
      |=> pattern_out.lane13_code == $past(reg_wdata_in[11:9], 2)
      && pattern_out.lane14_code == $past(reg_wdata_in[8:6], 2))
    else $error("Lane 13 or 14 code misrouted.");
  // The first edge after reset release still shows the reset value of k.
  a_filter_k_range: assert property (
      $past(resetn_in) |-> filter_out.k >= atrim_pkg::FILTER_K_MIN && filter_out.k <= atrim_pkg::FILTER_K_MAX)
    else $error("Filter k outside 2 to 10.");
  a_filter_enable: assert property (
      reg_wr_in && reg_addr_in == atrim_pkg::LANES13_16_PATTERN_FILTER_CTRL_ADDR ##1 !reg_wr_in
      |=> filter_out.enable == $past(reg_wdata_in[0], 2))
    else $error("Filter enable does not follow bit 0.");
  a_pattern_off: assert property (
      !per_lane_pattern_select_in |=> pattern_out == '0)
    else $error("Pattern fields leak without per-lane select.");
  a_read_timing: assert property (
      reg_rd_in && reg_addr_in == atrim_pkg::CONV16_ODD_GAIN_OFFSET_ADDR && !reg_wr_in
      |=> reg_rdata_out == $past(state_q.odd_trim) ##1 reg_rdata_out == 16'h0000 || $past(reg_rd_in))
    else $error("Read data not one cycle after strobe.");

  c_trim_both: cover property (sample_in.valid && global_gain_enable_in && global_offset_enable_in);
  c_prbs_on: cover property (pattern_out.prbs_en != 4'h0);
  c_filter_on: cover property (filter_out.enable && filter_out.k == 4'ha);

endmodule : atrim_regs

/* atrim_regs_test.sv */
// Self-checking bench for the converter-16 trim and lane 13-16 pattern/filter register bank.
// Assumes reads answer one cycle after the strobe and that every other output is registered once.
`timescale 1ns/1ps
module atrim_regs_test;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic gen = 1'b0;
  logic oen = 1'b0;
  logic psel = 1'b0;
  atrim_pkg::atrim_sample_t smp_in = '0;
  atrim_pkg::atrim_sample_t smp_out;
  atrim_pkg::atrim_pattern_t pat;
  atrim_pkg::atrim_filter_t filt;
  int miscompares = 0;
  int num_checks = 0;
  logic [15:0] w;
  logic [3:0] iv;
  logic [13:0] smp_tab [6] = '{14'h0064, 14'h20c0, 14'h1388, 14'h3ffd, 14'h0000, 14'h0400};

  // The clock inverts every half period, 25 ns in all.
  always #12.5 sys_clk_in = ~sys_clk_in;

  atrim_regs i_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .global_gain_enable_in(gen),
    .global_offset_enable_in(oen), .per_lane_pattern_select_in(psel), .sample_in(smp_in),
    .sample_out(smp_out), .pattern_out(pat), .filter_out(filt));

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe.
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  // One-cycle read strobe; the data are looked at in the one cycle they stand.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk

  // Offset subtraction, gain of N x 0.2 dB rounded to 14 fraction bits, floor shift and saturation.
  function automatic logic [13:0] model(input logic [15:0] r, input logic [13:0] s, input logic ge, input logic oe);
    longint d;
    longint g;
    d = longint'(signed'(s)) - (oe ? longint'(signed'(r[9:0])) : 64'sd0);
    g = longint'($rtoi(16384.0 * (10.0 ** (0.01 * r[15:11])) + 0.5));
    if (ge)
      d = (d * g) >>> 14;
    if (d > 8191)
      d = 8191;
    else if (d < -8192)
      d = -8192;
    return d[13:0];
  endfunction : model

  // Presents one sample and compares the corrected result a cycle later.
  task automatic smp_chk(input logic odd, input logic [13:0] s, input logic [15:0] r);
    @(posedge sys_clk_in);
    smp_in <= {1'b1, odd, s};
    @(posedge sys_clk_in);
    #1 chk(smp_out, {1'b1, odd, model(r, s, gen, oen)});
  endtask : smp_chk

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // Main sequence: reset, register map, pattern/filter fields, sample trim.
  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    rd_chk(8'h37, 16'h0000);
    rd_chk(8'h38, 16'h0000);
    rd_chk(8'h39, 16'h0000);
    chk(filt.enable, 1'b0);
    wr_reg(8'h37, 16'hffff);
    rd_chk(8'h37, 16'hfbff);
    wr_reg(8'h38, 16'hffff);
    rd_chk(8'h38, 16'hfbff);
    wr_reg(8'h39, 16'hffff);
    rd_chk(8'h39, 16'hffdf);
    wr_reg(8'h3a, 16'h1234);
    rd_chk(8'h3a, 16'h0000);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    // Every k code and every lane enable pattern, lane 13 included.
    for (int i = 0; i < 16; i++)
    begin
      iv = 4'(i);
      w = {iv, iv[2:0], ~iv[2:0], 1'b0, iv, iv[0]};
      wr_reg(8'h39, w);
      @(posedge sys_clk_in);
      #1 chk(pat, {iv, iv[2:0], ~iv[2:0]});
      chk(filt, {iv[0], (iv < 4'h2) ? 4'h2 : (iv > 4'ha) ? 4'ha : iv});
      rd_chk(8'h39, w);
    end
    @(posedge sys_clk_in);
    psel <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1 chk(pat, 10'h000);
    wr_reg(8'h37, 16'hfbfd);
    wr_reg(8'h38, 16'h39ff);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge sys_clk_in);
      gen <= c[1];
      oen <= c[0];
      for (int j = 0; j < 6; j++)
      begin
        smp_chk(1'b1, smp_tab[j], 16'hfbfd);
        smp_chk(1'b0, smp_tab[j], 16'h39ff);
      end
    end
    // Gain code zero with only gain on must leave the odd sample as it is.
    wr_reg(8'h37, 16'h03fd);
    oen <= 1'b0;
    smp_chk(1'b1, smp_tab[2], 16'h03fd);
    print_verdict();
  end
endmodule : atrim_regs_test
